/* File: verilog/gpio_pkg.sv */
// Shared constants and carriers for the per-pin general-purpose I/O block.
// Assumes a 32-bit Avalon-MM register bus and one 10 MHz system clock.
package gpio_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    // System clock period in ns
    localparam int CLK_PERIOD_NS = 100;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] CFG_OFFSET = 4'h0;  // Pin configuration
    localparam logic [3:0] STATUS_OFFSET = 4'h4;  // Pin state
    localparam logic [12:0] CFG_RESET = 13'h0000;  // All options off
    localparam int CFG_W = 13;  // Used configuration bits

    // ************************************************************
    // Configuration field positions
    // ************************************************************
    localparam int CFG_MODE_LSB = 0;  // Three mode bits
    localparam int CFG_IN_REG = 3;  // Register the input path
    localparam int CFG_IN_NEG = 4;  // Input register on falling edge
    localparam int CFG_OUT_REG = 5;  // Register the output path
    localparam int CFG_OUT_NEG = 6;  // Output and enable on falling edge
    localparam int CFG_OE_REG = 7;  // Register the output enable
    localparam int CFG_INVERT = 8;  // Invert value towards the pad
    localparam int CFG_DDR = 9;  // Double data mode
    localparam int CFG_RESYNC = 10;  // Resync variant of double data
    localparam int CFG_PULL_DN = 11;  // Unused pin pulls down
    localparam int CFG_DONE = 12;  // Configuration finished

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int ST_PAD_IN = 0;  // Pad level
    localparam int ST_CORE_IN = 1;  // Two bits towards the core
    localparam int ST_PAD_OE = 3;  // Pad driven
    localparam int ST_PAD_OUT = 4;  // Value driven
    localparam int ST_DIFF = 5;  // Differential-capable pin

    // ************************************************************
    // Pin modes
    // ************************************************************
    typedef enum logic [2:0]
    {
        MODE_UNUSED = 3'h0,
        MODE_INPUT = 3'h1,
        MODE_OUTPUT = 3'h2,
        MODE_BIDIR = 3'h3,
        MODE_CLKOUT = 3'h4
    } pin_mode_t;

    // Signals that go to the pad buffer together
    typedef struct packed
    {
        logic out;  // Value to drive
        logic oe;  // Drive enable, high while driving
        logic pull_up;  // Weak pull-up on
        logic pull_down;  // Weak pull-down on
    } pad_drive_t;

endpackage

/* File: verilog/gpio_edge_sense.sv */
// Edge detector for a clock-like level sampled by the system clock.
// Assumes the level is synchronous to clk and changes at most once a cycle.
`timescale 1ns/1ps
module gpio_edge_sense
(
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic rise,
    output logic fall
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed
    {
        logic prev;  // Level one cycle ago
    } edge_state_t;

    edge_state_t s_reg;  // Registered state
    edge_state_t s_next;  // Next state

    // Next state follows the level
    always_comb
    begin
        s_next = s_reg;
        s_next.prev = level;
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // One-cycle pulses on a change of level
    assign rise = level & ~s_reg.prev;
    assign fall = ~level & s_reg.prev;

endmodule

/* File: verilog/gpio_pin.sv */
// Per-pin I/O logic between core fabric and pad, with double data modes.
// Assumes pad, core and both core clocks are synchronous to clk; their
// edges are found by sampling. Registers sit on an Avalon-MM slave.
//
// What this block does
// - Input mode: input path only, optional edge register
// - Alternate input path is never registered
// - Double data input: rising and falling samples
// - Output mode: output path only, optional edge register
// - Optional inversion of output towards pad
// - Double data output: one register reloaded on each launch edge drives pad
// - Bidir: input, output, enable paths, own clocks
// - Bidir: own edge for input and for output/enable registers, input/output registering independent
// - Clock output mode forwards clock tree to pad
// - Disabled output buffer leaves pad undriven
// - During configuration: undriven with weak pull-up
// - Unused pins pull up, optionally pull down
// - Core input bit0 rising, bit1 falling sample
// - Alternate input only without register, to nets
// - Double data exchanges two bits per pin
// - Resync moves both bits to rising edge
// - Resync delays falling sample half a cycle
// - Differential-capable pin: no double data, no pull-down
// - Alternate input feeds PLL reference directly
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module gpio_pin
#(
    parameter bit DIFF_CAPABLE = 1'b0,  // Pin shares differential resources
    parameter int ADDR_W = 4  // Avalon byte address width
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pad_in,
    output gpio_pkg::pad_drive_t pad,
    output logic [1:0] core_in,
    input wire logic [1:0] core_out,
    input wire logic core_oe,
    input wire logic capture_clock,
    input wire logic launch_clock,
    input wire logic clock_tree_in,
    output logic global_clock_net,
    output logic global_control_net,
    output logic pll_reference_input
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    initial
    begin
        if (ADDR_W < 3 || ADDR_W > 16)
        begin
            $error("gpio_pin: ADDR_W must lie in 3..16");
        end
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed
    {
        logic [gpio_pkg::CFG_W-1:0] cfg;  // Configuration register
        logic ack;  // Bus answer pending
        logic [31:0] rdata;  // Read data
        logic in_sdr;  // Single-rate input register
        logic in_rise;  // Rising-edge input sample
        logic in_fall;  // Falling-edge input sample
        logic rs_rise;  // Resync rising bit
        logic rs_fall;  // Resync falling bit, half cycle later
        logic out_sdr;  // Single-rate output register
        logic oe_q;  // Registered output enable
        logic out_hold1;  // Resync falling value held from rise
        logic ddr_pad;  // Double data value towards pad
    } pin_state_t;

    pin_state_t s_reg;  // Registered state
    pin_state_t s_next;  // Next state

    logic cap_rise;  // Capture clock rose
    logic cap_fall;  // Capture clock fell
    logic lau_rise;  // Launch clock rose
    logic lau_fall;  // Launch clock fell
    gpio_pkg::pin_mode_t mode;  // Current mode
    logic done;  // Configuration finished
    logic in_path;  // Input path enabled
    logic out_path;  // Output path enabled
    logic ddr_in;  // Double data input active
    logic ddr_out;  // Double data output active
    logic alt_en;  // Alternate input enabled
    logic out_val;  // Output value before inversion
    logic oe_val;  // Output enable after registering
    logic req;  // Bus request present

    // ************************************************************
    // Helpers
    // ************************************************************
    // Pick the event of the configured edge
    function automatic logic sel_edge(input logic r, input logic f,
                                      input logic neg);
        sel_edge = neg ? f : r;
    endfunction

    // Merge write data into a register under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        be_merge = res;
    endfunction

    // ************************************************************
    // Clock edge detection
    // ************************************************************
    gpio_edge_sense u_cap_edge
    (
        .clk(clk),
        .rst(rst),
        .level(capture_clock),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    gpio_edge_sense u_lau_edge
    (
        .clk(clk),
        .rst(rst),
        .level(launch_clock),
        .rise(lau_rise),
        .fall(lau_fall)
    );

    // ************************************************************
    // Mode decode
    // ************************************************************
    assign mode = gpio_pkg::pin_mode_t'(s_reg.cfg[gpio_pkg::CFG_MODE_LSB +: 3]);
    assign done = s_reg.cfg[gpio_pkg::CFG_DONE];
    assign in_path = done && (mode == gpio_pkg::MODE_INPUT ||
                              mode == gpio_pkg::MODE_BIDIR);
    assign out_path = done && (mode == gpio_pkg::MODE_OUTPUT ||
                               mode == gpio_pkg::MODE_BIDIR);
    // Double data only in plain input or output mode
    assign ddr_in = done && mode == gpio_pkg::MODE_INPUT &&
                    s_reg.cfg[gpio_pkg::CFG_DDR];
    assign ddr_out = done && mode == gpio_pkg::MODE_OUTPUT &&
                     s_reg.cfg[gpio_pkg::CFG_DDR];
    // Alternate path only with no input register
    assign alt_en = done && mode == gpio_pkg::MODE_INPUT &&
                    !s_reg.cfg[gpio_pkg::CFG_IN_REG] &&
                    !s_reg.cfg[gpio_pkg::CFG_DDR];
    assign req = avs_read || avs_write;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [31:0] merged;
        logic cap_ev;
        logic lau_ev;
        merged = '0;
        s_next = s_reg;
        cap_ev = sel_edge(cap_rise, cap_fall,
                          s_reg.cfg[gpio_pkg::CFG_IN_NEG]);
        lau_ev = sel_edge(lau_rise, lau_fall,
                          s_reg.cfg[gpio_pkg::CFG_OUT_NEG]);
        // Bus: one wait cycle, answer on the second cycle
        s_next.ack = req && !s_reg.ack;
        if (req && !s_reg.ack)
        begin
            s_next.rdata = '0;
            if (avs_address == ADDR_W'(gpio_pkg::CFG_OFFSET))
            begin
                s_next.rdata[gpio_pkg::CFG_W-1:0] = s_reg.cfg;
            end
            else if (avs_address == ADDR_W'(gpio_pkg::STATUS_OFFSET))
            begin
                s_next.rdata[gpio_pkg::ST_PAD_IN] = pad_in;
                s_next.rdata[gpio_pkg::ST_CORE_IN +: 2] = core_in;
                s_next.rdata[gpio_pkg::ST_PAD_OE] = pad.oe;
                s_next.rdata[gpio_pkg::ST_PAD_OUT] = pad.out;
                s_next.rdata[gpio_pkg::ST_DIFF] = DIFF_CAPABLE;
            end
        end
        // Write takes effect when waitrequest is low
        if (avs_write && s_reg.ack &&
            avs_address == ADDR_W'(gpio_pkg::CFG_OFFSET))
        begin
            merged = be_merge({19'h00000, s_reg.cfg}, avs_writedata,
                              avs_byteenable);
            s_next.cfg = merged[gpio_pkg::CFG_W-1:0];
            if (DIFF_CAPABLE)
            begin
                s_next.cfg[gpio_pkg::CFG_DDR] = 1'b0;
                s_next.cfg[gpio_pkg::CFG_PULL_DN] = 1'b0;
            end
        end
        // Single-rate input register on the chosen capture edge
        if (in_path && !ddr_in && cap_ev)
        begin
            s_next.in_sdr = pad_in;
        end
        // Double data capture on both capture edges
        if (ddr_in && cap_rise)
        begin
            s_next.in_rise = pad_in;
            s_next.rs_rise = pad_in;
            s_next.rs_fall = s_reg.in_fall;
        end
        if (ddr_in && cap_fall)
        begin
            s_next.in_fall = pad_in;
        end
        // Single-rate output and enable registers
        if (out_path && !ddr_out && lau_ev)
        begin
            s_next.out_sdr = core_out[0];
        end
        if (out_path && lau_ev)
        begin
            s_next.oe_q = core_oe;
        end
        // Double data launch; resync takes both bits on the rise
        if (ddr_out && lau_rise)
        begin
            s_next.ddr_pad = core_out[0];
            s_next.out_hold1 = core_out[1];
        end
        if (ddr_out && lau_fall)
        begin
            s_next.ddr_pad = s_reg.cfg[gpio_pkg::CFG_RESYNC] ?
                             s_reg.out_hold1 : core_out[1];
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '{cfg: gpio_pkg::CFG_RESET, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Bus answer
    assign avs_waitrequest = req && !s_reg.ack;
    assign avs_readdata = s_reg.rdata;

    // Value and enable after registering
    always_comb
    begin
        if (ddr_out)
        begin
            out_val = s_reg.ddr_pad;
        end
        else if (s_reg.cfg[gpio_pkg::CFG_OUT_REG])
        begin
            out_val = s_reg.out_sdr;
        end
        else
        begin
            out_val = core_out[0];
        end
        case (mode)
            gpio_pkg::MODE_OUTPUT: oe_val = done;
            gpio_pkg::MODE_BIDIR: oe_val = done &&
                (s_reg.cfg[gpio_pkg::CFG_OE_REG] ? s_reg.oe_q : core_oe);
            gpio_pkg::MODE_CLKOUT: oe_val = done;
            default: oe_val = 1'b0;
        endcase
    end

    // Pad drive and pulls
    always_comb
    begin
        pad = '0;
        pad.oe = oe_val;
        if (mode == gpio_pkg::MODE_CLKOUT)
        begin
            pad.out = clock_tree_in;
        end
        else
        begin
            pad.out = out_val ^ s_reg.cfg[gpio_pkg::CFG_INVERT];
        end
        if (!done)
        begin
            pad.pull_up = 1'b1;
        end
        else if (mode == gpio_pkg::MODE_UNUSED)
        begin
            pad.pull_up = !s_reg.cfg[gpio_pkg::CFG_PULL_DN];
            pad.pull_down = s_reg.cfg[gpio_pkg::CFG_PULL_DN];
        end
    end

    // Data towards the core
    always_comb
    begin
        if (!in_path)
        begin
            core_in = 2'h0;
        end
        else if (ddr_in && s_reg.cfg[gpio_pkg::CFG_RESYNC])
        begin
            core_in = {s_reg.rs_fall, s_reg.rs_rise};
        end
        else if (ddr_in)
        begin
            core_in = {s_reg.in_fall, s_reg.in_rise};
        end
        else if (s_reg.cfg[gpio_pkg::CFG_IN_REG])
        begin
            core_in = {1'b0, s_reg.in_sdr};
        end
        else
        begin
            core_in = {1'b0, pad_in};
        end
    end

    // Unregistered alternate path to the dedicated nets
    assign global_clock_net = alt_en & pad_in;
    assign global_control_net = alt_en & pad_in;
    assign pll_reference_input = alt_en & pad_in;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    hiz_config_a: assert property (!done |-> !pad.oe && pad.pull_up &&
        !pad.pull_down) else $error("pin driven during configuration");
    unused_pull_a: assert property (done && mode == gpio_pkg::MODE_UNUSED
        |-> !pad.oe && (pad.pull_up != pad.pull_down))
        else $error("unused pin pull wrong");
    ddr_capture_a: assert property (ddr_in && cap_rise ##1 ddr_in &&
        !s_reg.cfg[gpio_pkg::CFG_RESYNC] |-> core_in[0] == $past(pad_in))
        else $error("rising sample lost");
    resync_half_a: assert property (ddr_in && cap_fall &&
        s_reg.cfg[gpio_pkg::CFG_RESYNC] ##3 cap_rise && ddr_in |=>
        core_in[1] == $past(pad_in, 4))
        else $error("resync falling bit wrong");
    out_reg_a: assert property (mode == gpio_pkg::MODE_OUTPUT && done &&
        !ddr_out && s_reg.cfg[gpio_pkg::CFG_OUT_REG] &&
        !s_reg.cfg[gpio_pkg::CFG_OUT_NEG] && lau_rise ##1
        $stable(s_reg.cfg) |-> pad.out ==
        ($past(core_out[0]) ^ s_reg.cfg[gpio_pkg::CFG_INVERT]))
        else $error("output register value wrong");
    release_a: assert property (done && mode == gpio_pkg::MODE_BIDIR &&
        !s_reg.cfg[gpio_pkg::CFG_OE_REG] && !core_oe |-> !pad.oe)
        else $error("pad not released");
    clkout_a: assert property (done && mode == gpio_pkg::MODE_CLKOUT
        |-> pad.oe && pad.out == clock_tree_in && core_in == 2'h0)
        else $error("clock output path wrong");
    diff_a: assert property (DIFF_CAPABLE |-> !s_reg.cfg[gpio_pkg::CFG_DDR]
        && !pad.pull_down) else $error("diff pin option set");
    alt_a: assert property (s_reg.cfg[gpio_pkg::CFG_IN_REG] |->
        !pll_reference_input && !global_clock_net)
        else $error("alternate path while registered");
    bus_wait_a: assert property (req && avs_waitrequest |=>
        !avs_waitrequest) else $error("bus answer late");

    ddr_resync_c: cover property (ddr_in &&
        s_reg.cfg[gpio_pkg::CFG_RESYNC] && cap_fall ##[1:20] cap_rise);
    bidir_turn_c: cover property (mode == gpio_pkg::MODE_BIDIR && pad.oe
        ##[1:20] !pad.oe);
    ddr_out_c: cover property (ddr_out && lau_rise ##[1:20] lau_fall);

endmodule

/* File: dv/pad_line_model.sv */
// Behavioural pad wire with an outside driver, feeding pad_in back.
// Assumes the pad carrier of gpio_pkg and a bench driver on ext_*.
`timescale 1ns/1ps
module pad_line_model
(
    input wire logic clk,
    input wire gpio_pkg::pad_drive_t pad,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pad_in
);
    logic last_reg;  // Last resolved level

    // Resolve the wire from every driver and the weak pulls
    always_comb
    begin
        if (pad.oe && ext_en)
            pad_in = 1'bx;  // Two drivers fight
        else if (pad.oe)
            pad_in = pad.out;
        else if (ext_en)
            pad_in = ext_val;
        else if (pad.pull_up)
            pad_in = 1'b1;
        else if (pad.pull_down)
            pad_in = 1'b0;
        else
            pad_in = ~last_reg;  // Floating: never keep the old level
    end

    // Remember the level for the floating case
    always_ff @(posedge clk)
    begin
        last_reg <= pad_in;
    end
endmodule

/* File: dv/gpio_pin_test.sv */
// Self-checking bench for gpio_pin over its register bus and pad side.
// Assumes pad_line_model on the pad and a 10 MHz system clock.
`timescale 1ns/1ps
module gpio_pin_test;
    logic clk, rst, avs_read, avs_write, avs_waitrequest, pad_in;
    logic capture_clock, launch_clock, clock_tree_in, core_oe;
    logic ext_en, ext_val;
    logic global_clock_net, global_control_net, pll_reference_input;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0] core_in, core_out;
    gpio_pkg::pad_drive_t pad;
    int mismatches, cmp_count, cyc;

    gpio_pin #(.DIFF_CAPABLE(1'b0)) i_dut (.*);
    pad_line_model i_pad (.*);

    // ****************************************
    // Clock and timeout
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cfg(input logic [31:0] v);
        bus(1'b1, gpio_pkg::CFG_OFFSET, v);
    endtask

    // Capture clock edge with a new pad value
    task automatic cap(input logic v);
        ext_val <= v;
        capture_clock <= ~capture_clock;
        repeat (3) @(posedge clk);
    endtask

    task automatic lau();
        launch_clock <= ~launch_clock;
        repeat (3) @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        {rst, avs_read, avs_write, capture_clock, launch_clock} = 5'h10;
        {clock_tree_in, core_oe, ext_en, ext_val, core_out} = 6'h00;
        {avs_address, avs_byteenable, avs_writedata} = {8'h0F, 32'h0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(pad) & 32'h7, 32'h2);
        bus(1'b0, gpio_pkg::CFG_OFFSET, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        $display("test reset finished");
        cfg(32'h1800);
        chk(32'(pad) & 32'h7, 32'h1);
        cfg(32'h1000);
        chk(32'(pad) & 32'h7, 32'h2);
        ext_en <= 1'b1;
        ext_val <= 1'b1;
        cfg(32'h1001);
        bus(1'b0, gpio_pkg::CFG_OFFSET, 32'h0);
        chk(rd, 32'h1001);
        chk(32'(pad) & 32'h7, 32'h0);
        chk({global_clock_net, global_control_net, pll_reference_input,
             core_in[0]}, 32'hF);
        ext_val <= 1'b0;
        repeat (2) @(posedge clk);
        chk({global_clock_net, pll_reference_input, core_in[0]}, 0);
        cfg(32'h1009);
        chk({global_clock_net, pll_reference_input}, 32'h0);
        cap(1'b1);
        chk(core_in[0], 32'h1);
        cap(1'b0);
        chk(core_in[0], 32'h1);
        cfg(32'h1019);
        cap(1'b0);
        chk(core_in[0], 32'h1);
        cap(1'b0);
        chk(core_in[0], 32'h0);
        $display("test input finished");
        cfg(32'h1209);
        cap(1'b1);
        chk(core_in[0], 32'h1);
        cap(1'b0);
        chk(core_in, 32'h1);
        cap(1'b0);
        chk(core_in, 32'h0);
        cap(1'b1);
        chk(core_in, 32'h2);
        cfg(32'h1609);
        cap(1'b1);
        cap(1'b0);
        cap(1'b1);
        chk(core_in, 32'h1);
        cap(1'b1);
        chk(core_in, 32'h1);
        cap(1'b0);
        chk(core_in, 32'h2);
        ext_en <= 1'b0;
        $display("test double input finished");
        cfg(32'h1102);  // Core drives bit 0
        chk(32'(pad), 32'hC);
        bus(1'b0, gpio_pkg::STATUS_OFFSET, 32'h0);
        chk(rd & 32'h19, 32'h19);
        cfg(32'h1122);
        lau();
        chk(32'(pad), 32'hC);
        core_out <= 2'b01;
        repeat (3) @(posedge clk);
        chk(32'(pad), 32'hC);
        lau();
        chk(32'(pad), 32'hC);
        lau();
        chk(32'(pad), 32'h4);
        cfg(32'h1222);
        core_out <= 2'b10;  // Falling value 1, then rising value 0
        lau();
        chk(32'(pad), 32'hC);
        lau();
        chk(32'(pad), 32'h4);
        $display("test output finished");
        core_out <= 2'b00;
        cfg(32'h1003);
        chk(32'(pad) & 32'h4, 32'h0);
        core_oe <= 1'b1;  // Enable from the core
        core_out <= 2'b01;
        repeat (2) @(posedge clk);
        chk(32'(pad), 32'hC);
        chk(core_in[0], 32'h1);
        lau();
        lau();
        cfg(32'h1083);
        core_oe <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(pad) & 32'h4, 32'h4);
        lau();
        lau();
        chk(32'(pad) & 32'h4, 32'h0);
        cfg(32'h1004);
        clock_tree_in <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(pad), 32'hC);
        clock_tree_in <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(pad), 32'h4);
        $display("test bidir and clock finished");
        wrap_up();
    end
endmodule
